//--- design/tsca_consts.svh
// constants and contract list for the temperature alert block
// Contract
// - power-down finishes conversion, then stops sensing
// - power-up state converts back to back
// - latch mode bit picks interrupt or comparator
// - active-level bit inverts alert pin, default low
// - fault field selects 1, 2, 4, 6 faults
// - period field selects 27.5/55/110/220 ms
// - one-shot in power-down runs one conversion
// - one-shot bit always reads back zero
// - comparator alert sets at/above upper limit
// - comparator alert releases below lower limit
// - interrupt alert sets at/above upper limit
// - register read or alert response clears interrupt alert
// - entering power-down clears interrupt alert
// - interrupt alert alternates upper and lower events
// - general call reset clears the alert
// - back to comparator clears alert state
// - limits move most significant byte first
// - limits hold 12 bits, low nibble zero
// - limits reset to 80 and 75 degrees
// - each byte is nine host clocks
// - device pulls ack low, host releases
// - host ack after byte one fetches byte two
// - selector byte latched for later reads
// - signed 12-bit compare in reading format
`ifndef TSCA_CONSTS_SVH
`define TSCA_CONSTS_SVH
`define TSCA_PTR_TEMP 2'h0
`define TSCA_PTR_CONF 2'h1
`define TSCA_PTR_LOW 2'h2
`define TSCA_PTR_HIGH 2'h3
`define TSCA_CONF_OS 7
`define TSCA_CONF_RST 8'h28
`define TSCA_LOW_RST 16'h4B00
`define TSCA_HIGH_RST 16'h5000
`define TSCA_CLK_NS 8
`define TSCA_CONV_BASE_US 27500
`define TSCA_CONV_BASE_CYC ((`TSCA_CONV_BASE_US * 1000) / `TSCA_CLK_NS)
`define TSCA_ARA_ADDR 7'h0C
`define TSCA_GC_ADDR 7'h00
`define TSCA_GC_RESET 8'h06
`define TSCA_LAST_BIT 4'h7
`define TSCA_ACK_BIT 4'h8
`endif

//--- design/tsca_pkg.sv
// types shared by the temperature alert block
package tsca_pkg;
    typedef enum {CONV_OFF, CONV_RUN} tsca_conv_e;
    typedef enum {BUS_IDLE, BUS_ADDR, BUS_WDATA, BUS_RDATA} tsca_bus_e;
    // setup byte bits 6..0, one-shot kept out
    typedef struct packed {
        logic conversion_period_sel_hi;
        logic conversion_period_sel_lo;
        logic fault_count_sel_hi;
        logic fault_count_sel_lo;
        logic alert_active_level;
        logic alert_latch_mode;
        logic power_down_request;
    } tsca_conf_s;
    // busy level and event toggles from the bus side
    typedef struct packed {
        logic busy;
        logic rd;
        logic ara;
        logic gc;
        logic os;
    } tsca_evt_s;
endpackage : tsca_pkg

//--- design/tsca_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module tsca_sync #(
    parameter int W = 1
) (
    // clock and reset of the receiving side
    input wire logic clk_in,
    input wire logic rst_n_in,
    // level in and synchronised level out
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= '0;
            q_out <= '0;
        end else begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end
endmodule : tsca_sync
`default_nettype wire

//--- design/tsca_top.sv
// temperature alert block: serial register access, conversion timing, alert
`timescale 1ns/1ns
`default_nettype none
`include "tsca_consts.svh"
module tsca_top #(
    parameter logic [6:0] DEV_ADDR = 7'h4A, // arbitrary target address
    parameter int unsigned CONV_BASE_CYC = `TSCA_CONV_BASE_CYC
) (
    // system clock and reset
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    // serial bus, open drain data
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // converter front end
    input wire logic [11:0] SENSE_CODE_IN,
    output logic CONV_ACTIVE_OUT,
    // alert pin
    output logic ALERT_OUT
);
    import tsca_pkg::*;

    // signed compare in reading format
    function automatic logic ge_s(input logic [11:0] a, input logic [11:0] b);
        ge_s = $signed(a) >= $signed(b);
    endfunction : ge_s

    // consecutive faults needed
    function automatic logic [2:0] fault_need(input tsca_conf_s c);
        case ({c.fault_count_sel_hi, c.fault_count_sel_lo})
            2'b00: fault_need = 3'h1;
            2'b01: fault_need = 3'h2;
            2'b10: fault_need = 3'h4;
            default: fault_need = 3'h6;
        endcase
    endfunction : fault_need

    // conversion length in clock cycles, base doubled per step
    function automatic logic [24:0] period_cyc(input tsca_conf_s c);
        logic [1:0] sel;
        sel = {c.conversion_period_sel_hi, c.conversion_period_sel_lo};
        period_cyc = 25'(CONV_BASE_CYC << sel);
    endfunction : period_cyc

    // ---------------- bus side, clocked by the host's SCL, start and stop by SDA edges ----------------
    logic start_tgl_ff, stop_tgl_ff, start_seen_ff;
    tsca_bus_e bus_st_ff;
    logic [3:0] bit_ff;
    logic [1:0] byte_ff, ptr_ff;
    logic [7:0] shift_ff, msb_ff;
    logic [15:0] tx_ff;
    logic ack_ff, rd_mode_ff, gc_mode_ff, ara_mode_ff;
    logic rd_tgl_ff, ara_tgl_ff, gc_tgl_ff, os_tgl_ff;
    tsca_conf_s bus_conf_ff;
    logic [11:0] bus_hi_ff, bus_lo_ff;
    logic alert_bus;
    logic new_frame, byte_done, ack_slot, addr_hit;
    logic [7:0] rx_byte;
    logic [15:0] rd_word;
    logic [11:0] temp_pub_ff;

    // start and stop are sda edges while scl is high; toggles keep them apart
    always_ff @(negedge SDA_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            start_tgl_ff <= 1'b0;
        end else if (SCL_IN) begin
            start_tgl_ff <= ~start_tgl_ff;
        end
    end

    always_ff @(posedge SDA_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            stop_tgl_ff <= 1'b0;
        end else if (SCL_IN) begin
            stop_tgl_ff <= ~stop_tgl_ff;
        end
    end

    // start hold time keeps the toggle settled before the first scl rise
    assign new_frame = start_tgl_ff != start_seen_ff;
    assign byte_done = bit_ff == `TSCA_LAST_BIT;
    assign ack_slot = bit_ff == `TSCA_ACK_BIT;
    assign rx_byte = {shift_ff[6:0], SDA_IN};
    assign addr_hit = rx_byte[7:1] == DEV_ADDR
        || rx_byte == {`TSCA_GC_ADDR, 1'b0}
        || (rx_byte == {`TSCA_ARA_ADDR, 1'b1} && alert_bus);

    // read word for the latched selector; one-shot position reads zero
    always_comb begin
        if (ara_mode_ff) begin
            rd_word = {DEV_ADDR, 1'b0, 8'h00};
        end else begin
            case (ptr_ff)
                `TSCA_PTR_TEMP: rd_word = {temp_pub_ff, 4'h0};
                `TSCA_PTR_CONF: rd_word = {2{1'b0, bus_conf_ff}};
                `TSCA_PTR_LOW: rd_word = {bus_lo_ff, 4'h0};
                default: rd_word = {bus_hi_ff, 4'h0};
            endcase
        end
    end

    // byte framing: eight data bits then the ack slot
    always_ff @(posedge SCL_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            start_seen_ff <= 1'b0;
            bus_st_ff <= BUS_IDLE;
            bit_ff <= 4'h0;
            byte_ff <= 2'h0;
            shift_ff <= 8'h00;
            tx_ff <= 16'h0000;
            ack_ff <= 1'b0;
            rd_mode_ff <= 1'b0;
            gc_mode_ff <= 1'b0;
            ara_mode_ff <= 1'b0;
        end else if (new_frame) begin
            start_seen_ff <= start_tgl_ff;
            bus_st_ff <= BUS_ADDR;
            bit_ff <= 4'h1;
            byte_ff <= 2'h0;
            shift_ff <= {7'h00, SDA_IN};
            ack_ff <= 1'b0;
        end else begin
            case (bus_st_ff)
                BUS_ADDR, BUS_WDATA: begin
                    if (ack_slot) begin
                        bit_ff <= 4'h0;
                        if (!ack_ff) begin
                            bus_st_ff <= BUS_IDLE;
                        end else if (bus_st_ff == BUS_ADDR && rd_mode_ff) begin
                            bus_st_ff <= BUS_RDATA;
                            tx_ff <= rd_word;
                        end else begin
                            bus_st_ff <= BUS_WDATA;
                        end
                        if (bus_st_ff == BUS_WDATA && byte_ff != 2'h2) begin
                            byte_ff <= byte_ff + 2'h1;
                        end
                    end else begin
                        shift_ff <= rx_byte;
                        bit_ff <= bit_ff + 4'h1;
                        if (byte_done && bus_st_ff == BUS_ADDR) begin
                            ack_ff <= addr_hit;
                            rd_mode_ff <= SDA_IN;
                            gc_mode_ff <= rx_byte == {`TSCA_GC_ADDR, 1'b0};
                            ara_mode_ff <= rx_byte[7:1] == `TSCA_ARA_ADDR;
                        end else if (byte_done) begin
                            ack_ff <= 1'b1;
                        end
                    end
                end
                BUS_RDATA: begin
                    if (ack_slot) begin
                        bit_ff <= 4'h0;
                        if (SDA_IN) begin
                            bus_st_ff <= BUS_IDLE; // host said no more
                        end
                    end else begin
                        bit_ff <= bit_ff + 4'h1;
                        tx_ff <= {tx_ff[14:0], 1'b0};
                    end
                end
                default: bus_st_ff <= BUS_IDLE;
            endcase
        end
    end

    // register writes: selector, then setup byte or limit msb, lsb
    always_ff @(posedge SCL_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ptr_ff <= `TSCA_PTR_TEMP;
            msb_ff <= 8'h00;
            bus_conf_ff <= tsca_conf_s'(7'(`TSCA_CONF_RST));
            bus_hi_ff <= 12'(`TSCA_HIGH_RST >> 4);
            bus_lo_ff <= 12'(`TSCA_LOW_RST >> 4);
        end else if (!new_frame && bus_st_ff == BUS_WDATA && byte_done) begin
            if (gc_mode_ff) begin
                if (rx_byte == `TSCA_GC_RESET) begin
                    ptr_ff <= `TSCA_PTR_TEMP;
                    bus_conf_ff <= tsca_conf_s'(7'(`TSCA_CONF_RST));
                    bus_hi_ff <= 12'(`TSCA_HIGH_RST >> 4);
                    bus_lo_ff <= 12'(`TSCA_LOW_RST >> 4);
                end
            end else begin
                case (byte_ff)
                    2'h0: ptr_ff <= rx_byte[1:0];
                    2'h1: begin
                        if (ptr_ff == `TSCA_PTR_CONF) begin
                            bus_conf_ff <= rx_byte[6:0];
                        end else begin
                            msb_ff <= rx_byte;
                        end
                    end
                    default: begin
                        if (ptr_ff == `TSCA_PTR_LOW) begin
                            bus_lo_ff <= {msb_ff, rx_byte[7:4]};
                        end else if (ptr_ff == `TSCA_PTR_HIGH) begin
                            bus_hi_ff <= {msb_ff, rx_byte[7:4]};
                        end
                    end
                endcase
            end
        end
    end

    // events for the core travel as toggles
    always_ff @(posedge SCL_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rd_tgl_ff <= 1'b0;
            ara_tgl_ff <= 1'b0;
            gc_tgl_ff <= 1'b0;
            os_tgl_ff <= 1'b0;
        end else if (!new_frame) begin
            if (bus_st_ff == BUS_ADDR && ack_slot && ack_ff && rd_mode_ff) begin
                if (ara_mode_ff) begin
                    ara_tgl_ff <= ~ara_tgl_ff;
                end else begin
                    rd_tgl_ff <= ~rd_tgl_ff;
                end
            end
            if (bus_st_ff == BUS_WDATA && byte_done && gc_mode_ff
                && rx_byte == `TSCA_GC_RESET) begin
                gc_tgl_ff <= ~gc_tgl_ff;
            end
            if (bus_st_ff == BUS_WDATA && byte_done && !gc_mode_ff && byte_ff == 2'h1
                && ptr_ff == `TSCA_PTR_CONF && rx_byte[`TSCA_CONF_OS]) begin
                os_tgl_ff <= ~os_tgl_ff;
            end
        end
    end

    // data changes on the falling edge; only ever pulls low
    always_ff @(negedge SCL_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            SDA_OE_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            SDA_OE_OUT <= ((bus_st_ff == BUS_ADDR || bus_st_ff == BUS_WDATA)
                && ack_slot && ack_ff)
                || (bus_st_ff == BUS_RDATA && !ack_slot && !tx_ff[15]);
        end
    end

    // ---------------- core side, on the reference clock, alert synchroniser on SCL ----------------
    tsca_evt_s evt_raw, evt_q, evt_prev_ff, evt_edge;
    tsca_conf_s cfg_ff, cfg_prev_ff;
    logic [11:0] hi_ff, lo_ff, temp_ff;
    tsca_conv_e conv_st_ff;
    logic [24:0] cnt_ff;
    logic [2:0] fcnt_ff;
    logic os_pend_ff, exp_low_ff, alert_ff;
    logic conv_done, fault_now, count_en, trip, tm_fell, sd_rise, int_clr;

    assign evt_raw = '{busy: start_tgl_ff ^ stop_tgl_ff, rd: rd_tgl_ff,
        ara: ara_tgl_ff, gc: gc_tgl_ff, os: os_tgl_ff};

    tsca_sync #(.W(5)) u_evt_sync (
        .clk_in(REF_CLK_IN),
        .rst_n_in(NRST_IN),
        .d_in(evt_raw),
        .q_out(evt_q)
    );

    tsca_sync #(.W(1)) u_alert_sync (
        .clk_in(SCL_IN),
        .rst_n_in(NRST_IN),
        .d_in(alert_ff),
        .q_out(alert_bus)
    );

    // settings and published reading swap only while the bus is quiet
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            evt_prev_ff <= '0;
            cfg_ff <= tsca_conf_s'(7'(`TSCA_CONF_RST));
            cfg_prev_ff <= tsca_conf_s'(7'(`TSCA_CONF_RST));
            hi_ff <= 12'(`TSCA_HIGH_RST >> 4);
            lo_ff <= 12'(`TSCA_LOW_RST >> 4);
            temp_pub_ff <= 12'h000;
        end else begin
            evt_prev_ff <= evt_q;
            cfg_prev_ff <= cfg_ff;
            if (!evt_q.busy) begin
                cfg_ff <= bus_conf_ff;
                hi_ff <= bus_hi_ff;
                lo_ff <= bus_lo_ff;
                temp_pub_ff <= temp_ff;
            end
        end
    end

    assign evt_edge = evt_q ^ evt_prev_ff;
    // at-or-past end: a shorter period written mid-run must not let the count wrap
    assign conv_done = conv_st_ff == CONV_RUN && cnt_ff >= period_cyc(cfg_ff) - 25'h1;
    assign tm_fell = cfg_prev_ff.alert_latch_mode && !cfg_ff.alert_latch_mode;
    assign sd_rise = !cfg_prev_ff.power_down_request && cfg_ff.power_down_request;

    // conversion scheduling
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            conv_st_ff <= CONV_RUN;
            cnt_ff <= 25'h0;
            temp_ff <= 12'h000;
            CONV_ACTIVE_OUT <= 1'b0;
        end else begin
            CONV_ACTIVE_OUT <= conv_st_ff == CONV_RUN;
            case (conv_st_ff)
                CONV_OFF: begin
                    if (!cfg_ff.power_down_request || os_pend_ff) begin
                        conv_st_ff <= CONV_RUN;
                        cnt_ff <= 25'h0;
                    end
                end
                CONV_RUN: begin
                    if (conv_done) begin
                        cnt_ff <= 25'h0;
                        temp_ff <= SENSE_CODE_IN;
                        if (cfg_ff.power_down_request) begin
                            conv_st_ff <= CONV_OFF;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 25'h1;
                    end
                end
                default: conv_st_ff <= CONV_OFF;
            endcase
        end
    end

    // one-shot request; a new request beats the consume
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            os_pend_ff <= 1'b0;
        end else begin
            os_pend_ff <= (evt_edge.os && cfg_ff.power_down_request)
                || (os_pend_ff && conv_st_ff != CONV_OFF);
        end
    end

    // fault filter looks at the fresh reading at the end of a conversion
    assign fault_now = exp_low_ff ? !ge_s(SENSE_CODE_IN, lo_ff)
        : ge_s(SENSE_CODE_IN, hi_ff);
    assign count_en = conv_done && (!cfg_ff.alert_latch_mode || !alert_ff);
    assign trip = count_en && fault_now && 3'(fcnt_ff + 3'h1) >= fault_need(cfg_ff);
    assign int_clr = cfg_ff.alert_latch_mode
        && (evt_edge.rd || evt_edge.ara || sd_rise);

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            fcnt_ff <= 3'h0;
        end else if (tm_fell || evt_edge.gc || trip) begin
            fcnt_ff <= 3'h0;
        end else if (count_en) begin
            fcnt_ff <= fault_now ? 3'(fcnt_ff + 3'h1) : 3'h0;
        end
    end

    // alert state; a trip in the same cycle as a clear wins
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            exp_low_ff <= 1'b0;
            alert_ff <= 1'b0;
        end else if (trip) begin
            exp_low_ff <= ~exp_low_ff;
            alert_ff <= cfg_ff.alert_latch_mode ? 1'b1 : ~exp_low_ff;
        end else if (tm_fell || evt_edge.gc) begin
            exp_low_ff <= 1'b0;
            alert_ff <= 1'b0;
        end else if (int_clr) begin
            alert_ff <= 1'b0;
        end
    end

    // pin level from the active-level bit
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ALERT_OUT <= 1'b1;
        end else begin
            ALERT_OUT <= cfg_ff.alert_active_level ? alert_ff : ~alert_ff;
        end
    end

    // ---------------- checks ----------------
    a_sd_stop: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        conv_done && cfg_ff.power_down_request |=> conv_st_ff == CONV_OFF)
        else $error("power-down did not stop after the conversion");
    a_cont_conv: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        conv_done && !cfg_ff.power_down_request |=> conv_st_ff == CONV_RUN && cnt_ff == 0)
        else $error("continuous conversion did not restart");
    a_os_start: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        conv_st_ff == CONV_OFF && os_pend_ff |=> conv_st_ff == CONV_RUN ##1 CONV_ACTIVE_OUT)
        else $error("one-shot did not start a conversion");
    a_pin_level: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        $stable(cfg_ff.alert_active_level) && !cfg_ff.alert_active_level && alert_ff
        |=> !ALERT_OUT)
        else $error("active-low alert pin not low");
    a_fault_restart: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        count_en && !fault_now && !tm_fell |=> fcnt_ff == 3'h0)
        else $error("fault count not restarted");
    a_comp_trip: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        !cfg_ff.alert_latch_mode && !alert_ff && trip |=> alert_ff && exp_low_ff)
        else $error("comparator alert did not assert");
    a_int_clear: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        int_clr && !trip |=> !alert_ff)
        else $error("interrupt alert not cleared");
    a_gc_clear: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        evt_edge.gc && !trip |=> !alert_ff ##1 (ALERT_OUT == cfg_prev_ff.alert_active_level ? 1'b0 : 1'b1))
        else $error("general call reset left alert set");
    a_period_len: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        conv_done && $stable(cfg_ff)
        |-> cnt_ff == 25'(CONV_BASE_CYC << {cfg_ff.conversion_period_sel_hi,
        cfg_ff.conversion_period_sel_lo}) - 25'h1)
        else $error("conversion length wrong");
    a_os_reads_zero: assert property (@(posedge SCL_IN) disable iff (!NRST_IN)
        bus_st_ff == BUS_ADDR && ack_slot && ack_ff && rd_mode_ff && !ara_mode_ff
        && ptr_ff == `TSCA_PTR_CONF |=> !tx_ff[15] && !tx_ff[7])
        else $error("one-shot bit read back as one");

    c_int_trip: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        cfg_ff.alert_latch_mode && trip);
    c_comp_release: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        !cfg_ff.alert_latch_mode && trip && exp_low_ff);
    c_one_shot: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        conv_st_ff == CONV_OFF && os_pend_ff);
endmodule : tsca_top
`default_nettype wire

//--- verif/tsca_host.sv
// serial bus host model: clocks only inside frames, open-drain data
`timescale 1ns/1ns
`default_nettype none
module tsca_host (
    // bus clock and data pull-down
    output logic scl_out,
    output logic sda_low_out,
    // resolved data line
    input wire logic sda_in
);
    // clock rests high on its pull-up between frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // data moves while the clock is low, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        #3 sda_low_out = !b;
        #4 scl_out = 1'b1;
        #4 r = sda_in;
        #4 scl_out = 1'b0;
    endtask : bit_io
    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_low_out = 1'b0;
        #4 scl_out = 1'b1;
        #4 sda_low_out = 1'b1;
        #4 scl_out = 1'b0;
    endtask : start
    // stop: data rises while the clock is high, bus then free
    task automatic stop();
        #3 sda_low_out = 1'b1;
        #4 scl_out = 1'b1;
        #4 sda_low_out = 1'b0;
        #8;
    endtask : stop
    // eight bits msb first, then the ack slot
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, ack); // release for device ack, or low for byte two
    endtask : xfer
endmodule : tsca_host
`default_nettype wire

//--- verif/tb_temp_sensor_config_alert.sv
// self-checking bench for the temperature alert block
`timescale 1ns/1ns
`default_nettype none
module tb_temp_sensor_config_alert;
    import tsca_pkg::*;
    localparam int BASE = 20;
    localparam logic [6:0] DEV = 7'h4A;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] code = 12'h000;
    logic scl, host_low, sda_out, sda_oe, conv, alert, ack;
    logic [7:0] q;
    logic [15:0] v;
    int n = 0;
    int run_len = 0;
    int bad_count = 0;
    int n_checks = 0;
    // wire level: pulled up unless someone pulls low
    wire logic sda = !(host_low || (sda_oe && !sda_out));
    always #4 ref_clk = !ref_clk;
    tsca_host host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));
    tsca_top #(.DEV_ADDR(DEV), .CONV_BASE_CYC(BASE)) dut (.REF_CLK_IN(ref_clk),
        .NRST_IN(nrst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_OUT(sda_oe), .SENSE_CODE_IN(code), .CONV_ACTIVE_OUT(conv),
        .ALERT_OUT(alert));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    // length of the latest converter run; a one-shot may start before the write returns
    always @(negedge ref_clk) begin
        if (conv === 1'b1) begin
            n <= n + 1;
        end else if (n != 0) begin
            run_len <= n;
            n <= 0;
        end
    end
    // selector then n bytes msb first; any missing ack is flagged
    task automatic wr(input logic [1:0] p, input int k, input logic [15:0] d);
        logic nak;
        host.start();
        host.xfer({DEV, 1'b0}, 1'b1, q, nak);
        host.xfer({6'h00, p}, 1'b1, q, ack);
        nak |= ack;
        for (int i = 0; i < k; i++) begin
            host.xfer(d[15-8*i -: 8], 1'b1, q, ack);
            nak |= ack;
        end
        host.stop();
        chk("write ack", nak, 1'b0);
    endtask : wr
    task automatic rd(output logic [15:0] r);
        host.start();
        host.xfer({DEV, 1'b1}, 1'b1, q, ack);
        chk("read ack", ack, 1'b0);
        host.xfer(8'hFF, 1'b0, r[15:8], ack);
        host.xfer(8'hFF, 1'b1, r[7:0], ack);
        host.stop();
    endtask : rd
    task automatic rdchk(input logic [1:0] p, input logic [15:0] e);
        wr(p, 0, 16'h0000);
        rd(v);
        chk("register", v, e);
    endtask : rdchk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // watchdog: the whole sequence needs about a ninth of this
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
    // main sequence
    initial begin
        cyc(8);
        nrst = 1'b1;
        cyc(2);
        chk("alert idle", alert, 1'b1);
        rdchk(2'h1, 16'h2828);
        rdchk(2'h2, 16'h4B00);
        rdchk(2'h3, 16'h5000);
        rd(v);
        chk("pointer kept", v, 16'h5000);
        wr(2'h3, 2, 16'h123F);
        rdchk(2'h3, 16'h1230);
        wr(2'h3, 2, 16'h0100);
        wr(2'h2, 2, 16'h0080);
        wr(2'h1, 1, 16'h9800);
        rdchk(2'h1, 16'h1818);
        // six faults needed; a clean reading in between restarts the run
        code = 12'h010;
        cyc(60);
        code = 12'h000;
        cyc(25);
        code = 12'h010;
        cyc(90);
        chk("no early trip", alert, 1'b1);
        cyc(40);
        chk("cmp trip", alert, 1'b0);
        code = 12'hF80;
        cyc(90);
        chk("cmp held", alert, 1'b0);
        cyc(40);
        chk("cmp release", alert, 1'b1);
        wr(2'h1, 1, 16'h1C00);
        cyc(5);
        chk("inverted", alert, 1'b0);
        // interrupt mode, one fault
        wr(2'h1, 1, 16'h0200);
        cyc(30);
        chk("no low first", alert, 1'b1);
        code = 12'h020;
        cyc(30);
        chk("int trip", alert, 1'b0);
        rd(v);
        cyc(5);
        chk("read clears", alert, 1'b1);
        cyc(30);
        chk("no repeat", alert, 1'b1);
        code = 12'hF80;
        cyc(30);
        chk("low event", alert, 1'b0);
        // alert response read: acked only while alert is up, returns own address
        host.start();
        host.xfer({7'h0C, 1'b1}, 1'b1, q, ack);
        chk("resp ack", ack, 1'b0);
        host.xfer(8'hFF, 1'b1, q, ack);
        host.stop();
        chk("resp addr", q, {DEV, 1'b0});
        cyc(5);
        chk("resp clears", alert, 1'b1);
        code = 12'h020;
        cyc(30);
        chk("int rearm", alert, 1'b0);
        wr(2'h1, 1, 16'h0300);
        cyc(5);
        chk("pd clears", alert, 1'b1);
        cyc(30);
        chk("stopped", conv, 1'b0);
        // one-shot length for every period code, comparator again
        for (int s = 0; s < 4; s++) begin
            wr(2'h1, 1, {1'b0, s[1:0], 5'h01, 8'h00});
            wr(2'h1, 1, {1'b1, s[1:0], 5'h01, 8'h00});
            cyc((BASE << s) + 10);
            chk("one-shot len", 16'(run_len), 16'(BASE << s));
            chk("back to off", conv, 1'b0);
        end
        wr(2'h1, 1, 16'h0000);
        code = 12'h7FF;
        cyc(60);
        chk("running trip", alert, 1'b0);
        // stop converting so no fresh trip can land between the reset and the check
        wr(2'h1, 1, 16'h0100);
        cyc(30);
        chk("stopped again", conv, 1'b0);
        host.start();
        host.xfer(8'h00, 1'b1, q, ack);
        host.xfer(8'h06, 1'b1, q, ack);
        host.stop();
        cyc(5);
        chk("gcall clears", alert, 1'b1);
        rdchk(2'h1, 16'h2828);
        complete_run();
    end
endmodule : tb_temp_sensor_config_alert
`default_nettype wire
